// [design/qdsc_consts.vh]
// register map, field positions, reset values and timing counts of the converter block
// Operation
// - status bits 7..4 report channel power-up
// - overcurrent without current limit clears power flag
// - status bits 3..0 report overcurrent alerts
// - mirrored flags read-only, reset to zero
// - update every (preload+1) times 10 us
// - time base from 40 MHz clock
// - set clear bit holds converter clear asserted
// - clear forces outputs to selected clear value
// - clear bits 31..8 reserved, written zero
// - mirror refreshed only on request or auto
// - timer modes trigger transfer and update
`ifndef QDSC_CONSTS_VH
`define QDSC_CONSTS_VH

`define QDSC_NCONV          8
`define QDSC_OFS_STATUS     8'h40
`define QDSC_OFS_PRELOAD    8'h60
`define QDSC_OFS_CLEAR      8'h80
`define QDSC_OFS_IRQ_STAT   8'h90
`define QDSC_OFS_IRQ_MASK   8'h94
`define QDSC_OFS_CONFIG     8'hA0

`define QDSC_STAT_PU_HI     7
`define QDSC_STAT_PU_LO     4
`define QDSC_STAT_OC_HI     3
`define QDSC_STAT_OC_LO     0

`define QDSC_CFG_MODE_HI    1
`define QDSC_CFG_MODE_LO    0
`define QDSC_CFG_AUTO       2
`define QDSC_CFG_CLEN       3
`define QDSC_CFG_CLSEL      4
`define QDSC_CFG_RUN        5
`define QDSC_CFG_RDREQ      6
`define QDSC_CFG_W          6

`define QDSC_MODE_FIFO      2'h2
`define QDSC_MODE_TIMER     2'h3

`define QDSC_RST_PRELOAD    32'h00000000
`define QDSC_RST_CLEAR      8'h00
`define QDSC_RST_STATUS     8'h00

`define QDSC_CLK_HZ         40000000
`define QDSC_TICK_NS        10000
`define QDSC_TICK_CYC       ((`QDSC_CLK_HZ / 1000000) * `QDSC_TICK_NS / 1000)

`endif

// [design/qdsc_conv_timer.v]
// per-converter sequencer down-counter producing update strobes
`timescale 1ns/1ps
module qdsc_conv_timer #(
  parameter W = 32
) (
  input  wire         clk_sys,
  input  wire         sys_rst,
  input  wire         tick,
  input  wire         run,
  input  wire [W-1:0] preload,
  output reg          update_q
);
  reg [W-1:0] cnt_q;
  reg         run_q;

  // counter restarts from the preload whenever the sequencer is (re)started
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q    <= {W{1'b0}};
      run_q    <= 1'b0;
      update_q <= 1'b0;
    end else begin
      run_q    <= run;
      update_q <= 1'b0;
      if (run && !run_q) begin
        cnt_q <= preload;
      end else if (run && tick) begin
        if (cnt_q == {W{1'b0}}) begin
          update_q <= 1'b1;
          cnt_q    <= preload;
        end else begin
          cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // qdsc_conv_timer

// [design/qdsc_top.v]
// converter status mirror, sequencer timers, clear control and APB slave
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "qdsc_consts.vh"
module qdsc_top #(
  parameter NCONV  = `QDSC_NCONV,
  parameter TMR_W  = 32,
  parameter TICK_N = `QDSC_TICK_CYC
) (
  input  wire               clk_sys,
  input  wire               sys_rst,
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [11:0]        paddr,
  input  wire [31:0]        pwdata,
  output wire               pready,
  output reg  [31:0]        prdata,
  output reg                pslverr,
  output reg  [NCONV-1:0]   stat_rd_req,
  input  wire [NCONV-1:0]   stat_rd_done,
  input  wire [8*NCONV-1:0] stat_rd_data,
  output wire [NCONV-1:0]   conv_update,
  output reg  [NCONV-1:0]   clear_conv,
  output wire [NCONV-1:0]   clear_value_select,
  output wire [NCONV-1:0]   current_limit_enable,
  output wire               irq
);
  // the divider is nine bits wide, so the terminal count is cut to that width on purpose
  localparam integer TICK_M1   = TICK_N - 1;
  localparam [8:0]   TICK_LAST = TICK_M1[8:0];

  reg  [8:0]           div_q;
  reg                  tick_q;
  reg  [7:0]           status_q  [0:NCONV-1];
  reg  [TMR_W-1:0]     preload_q [0:NCONV-1];
  reg  [`QDSC_CFG_W-1:0] cfg_q   [0:NCONV-1];
  reg  [NCONV-1:0]     pend_q;
  reg  [2*NCONV-1:0]   irq_stat_q;
  reg  [2*NCONV-1:0]   irq_mask_q;
  wire                 setup;
  wire                 wr_acc;
  wire [7:0]           ofs;
  wire [2:0]           sel;
  wire [NCONV-1:0]     run;
  wire [NCONV-1:0]     upd;
  wire [NCONV-1:0]     oc_rise;
  reg  [31:0]          rd_d;
  reg                  err_d;
  integer              i;
  integer              j;

  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign pready = 1'b1;
  assign ofs    = paddr[7:0];
  assign sel    = paddr[4:2];

  // 40 MHz / 400 gives the 10 us sequencer tick
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div_q  <= 9'h000;
      tick_q <= 1'b0;
    end else if (div_q == TICK_LAST) begin
      div_q  <= 9'h000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 9'h001;
      tick_q <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCONV; g = g + 1) begin : conv
      // only the fifo-fed and timer-fed modes let the sequencer pace updates
      assign run[g] = cfg_q[g][`QDSC_CFG_RUN] &&
                      (cfg_q[g][`QDSC_CFG_MODE_HI:`QDSC_CFG_MODE_LO] == `QDSC_MODE_FIFO ||
                       cfg_q[g][`QDSC_CFG_MODE_HI:`QDSC_CFG_MODE_LO] == `QDSC_MODE_TIMER);
      assign clear_value_select[g]   = cfg_q[g][`QDSC_CFG_CLSEL];
      assign current_limit_enable[g] = cfg_q[g][`QDSC_CFG_CLEN];
      assign oc_rise[g] = stat_rd_done[g] && (pend_q[g] || cfg_q[g][`QDSC_CFG_AUTO]) &&
                          (|(stat_rd_data[8*g+`QDSC_STAT_OC_HI:8*g+`QDSC_STAT_OC_LO] &
                             ~status_q[g][`QDSC_STAT_OC_HI:`QDSC_STAT_OC_LO]));
      qdsc_conv_timer #(
        .W (TMR_W)
      ) u_tmr (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .tick     (tick_q),
        .run      (run[g]),
        .preload  (preload_q[g]),
        .update_q (upd[g])
      );
    end
  endgenerate

  assign conv_update = upd;

  // status mirror, refreshed only by a requested or automatic status read
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 0; i < NCONV; i = i + 1) begin
        status_q[i] <= `QDSC_RST_STATUS;
      end
      pend_q      <= {NCONV{1'b0}};
      stat_rd_req <= {NCONV{1'b0}};
    end else begin
      stat_rd_req <= {NCONV{1'b0}};
      for (i = 0; i < NCONV; i = i + 1) begin
        if (stat_rd_done[i] && (pend_q[i] || cfg_q[i][`QDSC_CFG_AUTO])) begin
          status_q[i][`QDSC_STAT_OC_HI:`QDSC_STAT_OC_LO] <=
            stat_rd_data[8*i+`QDSC_STAT_OC_HI -: 4];
          // a channel with no current limit shuts down on overcurrent
          status_q[i][`QDSC_STAT_PU_HI:`QDSC_STAT_PU_LO] <=
            stat_rd_data[8*i+`QDSC_STAT_PU_HI -: 4] &
            ~(stat_rd_data[8*i+`QDSC_STAT_OC_HI -: 4] &
              {4{~cfg_q[i][`QDSC_CFG_CLEN]}});
        end
        // a new request wins over a completion arriving in the same cycle
        if (wr_acc && ofs == (`QDSC_OFS_CONFIG + {3'h0, i[2:0], 2'h0}) &&
            pwdata[`QDSC_CFG_RDREQ]) begin
          pend_q[i]      <= 1'b1;
          stat_rd_req[i] <= 1'b1;
        end else if (stat_rd_done[i]) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // software-written registers; the status mirror has no write path
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (j = 0; j < NCONV; j = j + 1) begin
        preload_q[j] <= `QDSC_RST_PRELOAD;
        cfg_q[j]     <= {`QDSC_CFG_W{1'b0}};
      end
      clear_conv <= `QDSC_RST_CLEAR;
      irq_mask_q <= {2*NCONV{1'b0}};
    end else if (wr_acc) begin
      if (ofs[7:5] == `QDSC_OFS_PRELOAD >> 5) begin
        preload_q[sel] <= pwdata[TMR_W-1:0];
      end
      if (ofs[7:5] == `QDSC_OFS_CONFIG >> 5) begin
        cfg_q[sel] <= pwdata[`QDSC_CFG_W-1:0];
      end
      if (ofs == `QDSC_OFS_CLEAR) begin
        clear_conv <= pwdata[NCONV-1:0];
      end
      if (ofs == `QDSC_OFS_IRQ_MASK) begin
        irq_mask_q <= pwdata[2*NCONV-1:0];
      end
    end
  end

  // sticky events: low byte overcurrent seen, high byte update done
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_q <= {2*NCONV{1'b0}};
    end else begin
      irq_stat_q <= (irq_stat_q &
                     ~((wr_acc && ofs == `QDSC_OFS_IRQ_STAT) ? pwdata[2*NCONV-1:0]
                                                             : {2*NCONV{1'b0}}))
                    | {upd, oc_rise};
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  always @* begin
    rd_d  = 32'h00000000;
    err_d = 1'b0;
    case (ofs[7:5])
      3'h2: rd_d[7:0] = status_q[sel];
      3'h3: rd_d[TMR_W-1:0] = preload_q[sel];
      3'h5: rd_d[`QDSC_CFG_W-1:0] = cfg_q[sel];
      3'h4: begin
        if (ofs == `QDSC_OFS_CLEAR) begin
          rd_d[NCONV-1:0] = clear_conv;
        end else if (ofs == `QDSC_OFS_IRQ_STAT) begin
          rd_d[2*NCONV-1:0] = irq_stat_q;
        end else if (ofs == `QDSC_OFS_IRQ_MASK) begin
          rd_d[2*NCONV-1:0] = irq_mask_q;
        end else begin
          err_d = 1'b1;
        end
      end
      default: err_d = 1'b1;
    endcase
    if (paddr[11:8] != 4'h0 || paddr[1:0] != 2'h0) begin
      err_d = 1'b1;
    end
  end

  // read data and error are captured in the setup cycle so they leave flip-flops
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h00000000 : rd_d;
      pslverr <= err_d;
    end
  end
endmodule // qdsc_top

// [tb/qdsc_assertions.sv]
// port checker for the converter status, timer and clear block
`timescale 1ns/1ps
module qdsc_chk #(
  parameter NCONV = 8
) (
  input wire logic             clk_sys,
  input wire logic             sys_rst,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic             pready,
  input wire logic [31:0]      prdata,
  input wire logic [NCONV-1:0] stat_rd_req,
  input wire logic [NCONV-1:0] conv_update,
  input wire logic [NCONV-1:0] clear_conv,
  input wire logic [NCONV-1:0] current_limit_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire acc     = psel && penable;
  wire clr_wr  = acc && pwrite && paddr == 12'h080;
  wire cfg0_wr = acc && pwrite && paddr == 12'h0A0;
  sequence s_req_pulse;
    stat_rd_req[0] ##1 !stat_rd_req[0];
  endsequence
  sequence s_clr_rd;
    psel && !penable && !pwrite && paddr == 12'h080;
  endsequence
  a_ready_in_access: assert property (acc |-> pready) else $error("pready low in access");
  a_clear_follows: assert property (clr_wr |=> clear_conv == $past(pwdata[NCONV-1:0]))
    else $error("clear lines differ from written bits");
  a_clear_holds: assert property (!$stable(clear_conv) |-> $past(clr_wr))
    else $error("clear lines moved without a write");
  a_req_one_pulse: assert property (cfg0_wr && pwdata[6] |=> s_req_pulse)
    else $error("status request not a single pulse");
  a_req_has_cause: assert property (stat_rd_req[0] |-> $past(cfg0_wr && pwdata[6]))
    else $error("status request without software order");
  a_limit_follows: assert property (cfg0_wr |=> current_limit_enable[0] == $past(pwdata[3]))
    else $error("current limit enable not taken from write");
  // with the simulation tick of four clocks no interval can be shorter than four
  a_update_gap: assert property (conv_update[0] |=> (!conv_update[0]) [*3])
    else $error("update strobes too close");
  a_clear_reserved: assert property (s_clr_rd |=> prdata[31:8] == 24'h0)
    else $error("clear register upper bits not zero");
endmodule // qdsc_chk
bind qdsc_top qdsc_chk #(.NCONV(NCONV)) i_chk (.*);

// [tb/qdsc_dac_model.sv]
// behavioural status responder standing in for the eight quad converter chips
`timescale 1ns/1ps
module qdsc_dac_model (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  stat_rd_req,
  input  wire logic [63:0] chip_stat,
  input  wire logic [1:0]  lag,
  input  wire logic [7:0]  poke,
  output logic      [7:0]  stat_rd_done,
  output logic      [63:0] stat_rd_data
);
  logic [2:0] wait_q [8] = '{default: 3'h0};
  initial stat_rd_done = 8'h00;
  initial stat_rd_data = 64'h0;
  // data toggles outside a done pulse so a stale byte never passes as fresh
  always @(posedge clk_sys) begin
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      stat_rd_done[i] <= poke[i] || wait_q[i] == 3'h1;
      hit = hit || poke[i] || wait_q[i] == 3'h1;
      if (stat_rd_req[i]) wait_q[i] <= {1'b0, lag} + 3'h1;
      else if (wait_q[i] != 3'h0) wait_q[i] <= wait_q[i] - 3'h1;
    end
    stat_rd_data <= hit ? chip_stat : ~stat_rd_data;
  end
endmodule // qdsc_dac_model

// [tb/tb.sv]
// self-checking bench for the converter status, timer and clear block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, irq, i1;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cfg, e0, s0;
  logic [7:0]  stat_rd_req, stat_rd_done, conv_update, clear_conv, poke, st;
  logic [7:0]  clear_value_select, current_limit_enable;
  logic [63:0] stat_rd_data, chip_stat;
  logic [1:0]  lag;
  logic [32:0] expq [$];
  int          error_cnt, compares, n;
  qdsc_top #(.TICK_N(4)) i_dut (.*);
  qdsc_dac_model i_dac (.*);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic conclude;
    $display("mismatches=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one idle cycle per transfer keeps every strobe to one assignment per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) expq.push_back(e);
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 50);
    if (n == 50) begin error_cnt++; conclude(); end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // waits for an update strobe when upd is set, else for a status read completion
  task automatic wt(input logic upd, input int b, input int lim);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while ((upd ? conv_update[b] : stat_rd_done[b]) !== 1'b1 && n < lim);
    if (n == lim) begin error_cnt++; conclude(); end
  endtask
  function automatic logic [11:0] ad(input logic [11:0] b, input int i);
    return b + 12'(4 * i);
  endfunction
  always @(posedge clk_sys)
    if (psel && penable && !pwrite && pready && expq.size() > 0) `CHK({pslverr, prdata}, expq.pop_front())
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {chip_stat, lag, poke} = 74'h0;
    n = $urandom(32'h57BA);
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, ad(12'h040, i), 32'hFF, 33'h0);
      apb(1'b0, ad(12'h040, i), 32'h0, 33'h0);
      apb(1'b0, ad(12'h060, i), 32'h0, 33'h0);
    end
    cfg = $urandom;
    apb(1'b1, 12'h06C, cfg, 33'h0);
    apb(1'b0, 12'h06C, 32'h0, {1'b0, cfg});
    apb(1'b0, 12'h080, 32'h0, 33'h0);
    apb(1'b1, 12'h080, 32'hA5, 33'h0);
    apb(1'b0, 12'h080, 32'h0, 33'h0A5);
    `CHK(clear_conv, 8'hA5)
    apb(1'b1, 12'h080, 32'h0, 33'h0);
    apb(1'b0, 12'h0FC, 32'h0, {1'b1, 32'h0});
    for (int i = 0; i < 8; i++) begin
      cfg = $urandom & 32'h18;
      st = 8'($urandom);
      chip_stat[8*i +: 8] <= st;
      lag <= 2'($urandom);
      apb(1'b1, ad(12'h0A0, i), cfg | 32'h40, 33'h0);
      wt(1'b0, i, 20);
      e0 = {24'h0, st[7:4] & ~(st[3:0] & {4{~cfg[3]}}), st[3:0]};
      if (i == 0) s0 = e0;
      apb(1'b0, ad(12'h040, i), 32'h0, {1'b0, e0});
      `CHK(current_limit_enable[i], cfg[3])
      `CHK(clear_value_select[i], cfg[4])
    end
    apb(1'b1, 12'h0A0, 32'h0, 33'h0);
    for (int k = 0; k < 2; k++) begin
      chip_stat[7:0] <= 8'hF5;
      poke <= 8'h01;
      @(posedge clk_sys);
      poke <= 8'h00;
      repeat (3) @(posedge clk_sys);
      apb(1'b0, 12'h040, 32'h0, k ? 33'hA5 : {1'b0, s0});
      apb(1'b1, 12'h0A0, 32'h4, 33'h0);
      e0 = 32'hA5;
    end
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, ad(12'h060, m), m ? 32'h0 : 32'h2, 33'h0);
      apb(1'b1, ad(12'h0A0, m), m ? 32'h22 : 32'h23, 33'h0);
      wt(1'b1, m, 60);
      wt(1'b1, m, 60);
      `CHK(n, m ? 4 : 12)
      apb(1'b1, ad(12'h0A0, m), 32'h0, 33'h0);
    end
    apb(1'b1, 12'h094, 32'hFFFF, 33'h0);
    @(negedge clk_sys);
    i1 = irq;
    apb(1'b1, 12'h094, 32'h0, 33'h0);
    @(negedge clk_sys);
    `CHK(i1, 1'b1)
    `CHK(irq, 1'b0)
    apb(1'b1, 12'h090, 32'hFFFFFFFF, 33'h0);
    apb(1'b0, 12'h090, 32'h0, 33'h0);
    // unmask again so a bit that survived the clear would show on the line
    apb(1'b1, 12'h094, 32'hFFFF, 33'h0);
    @(negedge clk_sys);
    `CHK(irq, 1'b0)
    `CHK(expq.size(), 0)
    conclude();
  end
endmodule // tb
